// >>> pkg/mbx_pkg.sv
// constants shared by the mailbox port and its queue
// assumes one clock; offsets decoded on the low address nibble
package mbx_pkg;

	// response codes, same on write and read channels
	localparam logic [1:0] MBX_RESP_OKAY   = 2'h0;
	localparam logic [1:0] MBX_RESP_SLVERR = 2'h2;
	localparam logic [1:0] MBX_RESP_DECERR = 2'h3;

	// register offsets on the low nibble of the byte address
	localparam int         MBX_OFF_W       = 4;
	localparam logic [3:0] MBX_OFF_TXDATA  = 4'h0;
	localparam logic [3:0] MBX_OFF_TXLAST  = 4'h4;
	localparam logic [3:0] MBX_OFF_RXDATA  = 4'h8;
	localparam logic [3:0] MBX_OFF_STATUS  = 4'hc;

	// status word bit positions
	localparam int MBX_ST_RXEMPTY = 0;
	localparam int MBX_ST_TXFULL  = 1;
	localparam int MBX_ST_RXLAST  = 2;

	// values after reset
	localparam logic MBX_ARREADY_RST = 1'h1;
	localparam logic MBX_WREADY_RST  = 1'h0;
	localparam logic MBX_BVALID_RST  = 1'h0;
	localparam logic MBX_RVALID_RST  = 1'h0;
	localparam logic MBX_TREADY_RST  = 1'h0;
	localparam logic MBX_TVALID_RST  = 1'h0;

	// default queue depth
	localparam int MBX_DEPTH_DEF = 16;

	typedef enum logic [2:0] {
		MBX_W_IDLE = 3'h1,
		MBX_W_ACC  = 3'h2,
		MBX_W_RESP = 3'h4
	} mbx_wr_e;

	typedef enum logic [2:0] {
		MBX_R_ADDR = 3'h1,
		MBX_R_DATA = 3'h2,
		MBX_R_RESP = 3'h4
	} mbx_rd_e;

endpackage

// >>> rtl/mbx_queue.sv
// one direction of the mailbox queue with a registered head word
// assumes DEPTH is a power of two and both sides share the clock
`timescale 1ns/1ps
`default_nettype none
module mbx_queue
	import mbx_pkg::*;
#(
	parameter int W     = 33,
	parameter int DEPTH = MBX_DEPTH_DEF
) (
	// clock, enable, reset
	input  wire logic         clk_sys_i,
	input  wire logic         ce_i,
	input  wire logic         srst_i,
	// fill side
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	// drain side
	input  wire logic         out_ready_i,
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr;
		logic [AW-1:0]           rd;
		logic [AW:0]             cnt;
		logic                    hv;
		logic [W-1:0]            hd;
		logic                    in_ready;
	} mbx_q_s;

	mbx_q_s r_r;
	mbx_q_s r_nxt;
	logic   push;
	logic   load;

	always_comb begin
		r_nxt = r_r;
		push  = in_valid_i && r_r.in_ready;
		// refill the head whenever it is empty or being taken
		load  = (r_r.cnt != '0) && (!r_r.hv || out_ready_i);
		if (r_r.hv && out_ready_i) begin
			r_nxt.hv = 1'b0;
		end
		if (load) begin
			r_nxt.hd = r_r.mem[r_r.rd];
			r_nxt.hv = 1'b1;
			r_nxt.rd = r_r.rd + 1'b1;
		end
		if (push) begin
			r_nxt.mem[r_r.wr] = in_data_i;
			r_nxt.wr = r_r.wr + 1'b1;
		end
		if (push && !load) begin
			r_nxt.cnt = r_r.cnt + 1'b1;
		end else if (!push && load) begin
			r_nxt.cnt = r_r.cnt - 1'b1;
		end
		r_nxt.in_ready = (r_nxt.cnt != CNT_FULL);
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			r_r          <= '0;
			r_r.in_ready <= MBX_TREADY_RST;
			r_r.hv       <= MBX_TVALID_RST;
		end else if (ce_i) begin
			r_r <= r_nxt;
		end
	end

	assign in_ready_o  = r_r.in_ready;
	assign out_valid_o = r_r.hv;
	assign out_data_o  = r_r.hd;

endmodule
`default_nettype wire

// >>> rtl/mbx_axi_port.sv
// mailbox with a register-mapped bus port and two stream ports
// assumes both stream clocks are the bus clock; far side is logic
// What this block does
// - write byte strobes are ignored; every write replaces the whole word
// - write response codes: 00 okay, 10 slave error, 11 decode error
// - read response uses the same three codes as the write response
// - write-data ready is low after reset, high only when data can be taken
// - write response valid low and code zero after reset until one exists
// - read-address ready is high straight after reset
// - read valid, data and code zero after reset until data is ready
// - inbound stream ready low after reset, high only when a word fits
// - stream valid means both data word and last flag are valid
// - the sender flags the final word of a transfer with last
// - outbound stream valid, last and data are zero until a word exists
// - the bus port reset input is active low
// - the mailbox runs on the bus port clock
`timescale 1ns/1ps
`default_nettype none
module mbx_axi_port
	import mbx_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int DW     = 32,
	parameter int DEPTH  = MBX_DEPTH_DEF
) (
	// clock, enable, resets
	input  wire logic              clk_sys_i,
	input  wire logic              ce_i,
	input  wire logic              srst_i,
	input  wire logic              s_axi_aresetn_i,
	// bus write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	// bus write data
	input  wire logic [DW-1:0]     s_axi_wdata_i,
	input  wire logic [DW/8-1:0]   s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	// bus write response
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	// bus read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	// bus read data
	output logic [DW-1:0]          s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	// inbound stream
	input  wire logic [DW-1:0]     s_axis_tdata_i,
	input  wire logic              s_axis_tlast_i,
	input  wire logic              s_axis_tvalid_i,
	output logic                   s_axis_tready_o,
	// outbound stream
	output logic [DW-1:0]          m_axis_tdata_o,
	output logic                   m_axis_tlast_o,
	output logic                   m_axis_tvalid_o,
	input  wire logic              m_axis_tready_i
);
	typedef struct packed {
		mbx_wr_e              wst;
		logic                 awready;
		logic                 wready;
		logic                 bvalid;
		logic [1:0]           bresp;
		mbx_rd_e              rst;
		logic                 arready;
		logic [MBX_OFF_W-1:0] raddr;
		logic                 rvalid;
		logic [DW-1:0]        rdata;
		logic [1:0]           rresp;
		logic                 rxlast;
	} mbx_port_s;

	mbx_port_s     r_r;
	mbx_port_s     r_nxt;
	logic          rst_all;
	logic [MBX_OFF_W-1:0] waddr;
	logic          tx_push;
	logic [DW:0]   tx_word;
	logic          tx_ready;
	logic          rx_pop;
	logic          rx_valid;
	logic [DW:0]   rx_word;
	logic [DW:0]   tx_head;
	logic          rx_ready;

	// either the system reset or the low-active bus reset clears all
	assign rst_all = srst_i || !s_axi_aresetn_i;
	assign waddr   = s_axi_awaddr_i[MBX_OFF_W-1:0];

	always_comb begin
		r_nxt   = r_r;
		tx_push = 1'b0;
		// full word always written, strobes not looked at
		tx_word = {1'b0, s_axi_wdata_i};
		rx_pop  = 1'b0;

		// write side: both address and data present, then take them
		case (r_r.wst)
			MBX_W_IDLE: begin
				if (s_axi_awvalid_i && s_axi_wvalid_i) begin
					r_nxt.awready = 1'b1;
					r_nxt.wready  = 1'b1;
					r_nxt.wst     = MBX_W_ACC;
				end
			end
			MBX_W_ACC: begin
				r_nxt.awready = 1'b0;
				r_nxt.wready  = 1'b0;
				if (waddr == MBX_OFF_TXDATA || waddr == MBX_OFF_TXLAST) begin
					tx_word[DW] = (waddr == MBX_OFF_TXLAST);
					if (tx_ready) begin
						tx_push = 1'b1;
						r_nxt.bresp = MBX_RESP_OKAY;
					end else begin
						r_nxt.bresp = MBX_RESP_SLVERR;
					end
				end else if (waddr == MBX_OFF_RXDATA ||
					     waddr == MBX_OFF_STATUS) begin
					r_nxt.bresp = MBX_RESP_SLVERR;
				end else begin
					r_nxt.bresp = MBX_RESP_DECERR;
				end
				r_nxt.bvalid = 1'b1;
				r_nxt.wst    = MBX_W_RESP;
			end
			MBX_W_RESP: begin
				// response stands until taken
				if (s_axi_bready_i) begin
					r_nxt.bvalid = 1'b0;
					r_nxt.bresp  = MBX_RESP_OKAY;
					r_nxt.wst    = MBX_W_IDLE;
				end
			end
			default: begin
				r_nxt.wst = MBX_W_IDLE;
			end
		endcase

		// read side: address taken while ready, rvalid raised two cycles later
		case (r_r.rst)
			MBX_R_ADDR: begin
				// address sampled on the handshake edge only
				if (s_axi_arvalid_i) begin
					r_nxt.raddr   = s_axi_araddr_i[MBX_OFF_W-1:0];
					r_nxt.arready = 1'b0;
					r_nxt.rst     = MBX_R_DATA;
				end
			end
			MBX_R_DATA: begin
				r_nxt.rdata = '0;
				if (r_r.raddr == MBX_OFF_RXDATA) begin
					if (rx_valid) begin
						rx_pop       = 1'b1;
						r_nxt.rdata  = rx_word[DW-1:0];
						r_nxt.rxlast = rx_word[DW];
						r_nxt.rresp  = MBX_RESP_OKAY;
					end else begin
						r_nxt.rresp  = MBX_RESP_SLVERR;
					end
				end else if (r_r.raddr == MBX_OFF_STATUS) begin
					r_nxt.rdata[MBX_ST_RXEMPTY] = !rx_valid;
					r_nxt.rdata[MBX_ST_TXFULL]  = !tx_ready;
					r_nxt.rdata[MBX_ST_RXLAST]  = r_r.rxlast;
					r_nxt.rresp = MBX_RESP_OKAY;
				end else if (r_r.raddr == MBX_OFF_TXDATA ||
					     r_r.raddr == MBX_OFF_TXLAST) begin
					r_nxt.rresp = MBX_RESP_SLVERR;
				end else begin
					r_nxt.rresp = MBX_RESP_DECERR;
				end
				r_nxt.rvalid = 1'b1;
				r_nxt.rst    = MBX_R_RESP;
			end
			MBX_R_RESP: begin
				if (s_axi_rready_i) begin
					r_nxt.rvalid  = 1'b0;
					r_nxt.rdata   = '0;
					r_nxt.rresp   = MBX_RESP_OKAY;
					r_nxt.arready = 1'b1;
					r_nxt.rst     = MBX_R_ADDR;
				end
			end
			default: begin
				r_nxt.rst = MBX_R_ADDR;
			end
		endcase
	end

	// whole mailbox on the bus port clock
	always_ff @(posedge clk_sys_i) begin
		if (rst_all) begin
			r_r         <= '0;
			r_r.wst     <= MBX_W_IDLE;
			r_r.wready  <= MBX_WREADY_RST;
			r_r.bvalid  <= MBX_BVALID_RST;
			r_r.bresp   <= MBX_RESP_OKAY;
			r_r.rst     <= MBX_R_ADDR;
			r_r.arready <= MBX_ARREADY_RST;
			r_r.rvalid  <= MBX_RVALID_RST;
		end else if (ce_i) begin
			r_r <= r_nxt;
		end
	end

	// bus to outbound stream; head held until the sink takes it
	mbx_queue #(
		.W     (DW + 1),
		.DEPTH (DEPTH)
	) u_tx (
		.clk_sys_i   (clk_sys_i),
		.ce_i        (ce_i),
		.srst_i      (rst_all),
		.in_valid_i  (tx_push),
		.in_data_i   (tx_word),
		.in_ready_o  (tx_ready),
		.out_ready_i (m_axis_tready_i),
		.out_valid_o (m_axis_tvalid_o),
		.out_data_o  (tx_head)
	);

	// inbound stream to bus; data and last captured as one word
	mbx_queue #(
		.W     (DW + 1),
		.DEPTH (DEPTH)
	) u_rx (
		.clk_sys_i   (clk_sys_i),
		.ce_i        (ce_i),
		.srst_i      (rst_all),
		.in_valid_i  (s_axis_tvalid_i),
		.in_data_i   ({s_axis_tlast_i, s_axis_tdata_i}),
		.in_ready_o  (rx_ready),
		.out_ready_i (rx_pop),
		.out_valid_o (rx_valid),
		.out_data_o  (rx_word)
	);

	assign s_axis_tready_o = rx_ready;
	assign m_axis_tdata_o  = tx_head[DW-1:0];
	assign m_axis_tlast_o  = tx_head[DW];
	assign s_axi_awready_o = r_r.awready;
	assign s_axi_wready_o  = r_r.wready;
	assign s_axi_bresp_o   = r_r.bresp;
	assign s_axi_bvalid_o  = r_r.bvalid;
	assign s_axi_arready_o = r_r.arready;
	assign s_axi_rdata_o   = r_r.rdata;
	assign s_axi_rresp_o   = r_r.rresp;
	assign s_axi_rvalid_o  = r_r.rvalid;

endmodule
`default_nettype wire

// >>> verif/mbx_checker.sv
// assertions on the mailbox bus and stream ports
// bound to mbx_axi_port; one clock, both resets synchronous
`timescale 1ns/1ps
`default_nettype none
module mbx_checker
	import mbx_pkg::*;
#(parameter int DW = 32) (
	// clock and resets
	input wire logic		clk_sys_i,
	input wire logic		srst_i,
	input wire logic		s_axi_aresetn_i,
	// bus side
	input wire logic		s_axi_awready_o,
	input wire logic		s_axi_wready_o,
	input wire logic [1:0]	s_axi_bresp_o,
	input wire logic		s_axi_bvalid_o,
	input wire logic		s_axi_bready_i,
	input wire logic		s_axi_arvalid_i,
	input wire logic		s_axi_arready_o,
	input wire logic [DW-1:0]	s_axi_rdata_o,
	input wire logic [1:0]	s_axi_rresp_o,
	input wire logic		s_axi_rvalid_o,
	input wire logic		s_axi_rready_i,
	// stream side
	input wire logic		s_axis_tready_o,
	input wire logic [DW-1:0]	m_axis_tdata_o,
	input wire logic		m_axis_tlast_o,
	input wire logic		m_axis_tvalid_o,
	input wire logic		m_axis_tready_i
);
	logic rst;
	assign rst = srst_i || !s_axi_aresetn_i;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst);
	a_rst_bus: assert property (
		$past(rst) |-> !s_axi_wready_o && !s_axi_bvalid_o && s_axi_arready_o
		&& s_axi_bresp_o == 2'h0 && !s_axi_rvalid_o)
		else $error("bus outputs off reset values");
	a_rst_strm: assert property (
		$past(rst) |-> !s_axis_tready_o && !m_axis_tvalid_o
		&& !m_axis_tlast_o && m_axis_tdata_o == '0)
		else $error("stream outputs off reset values");
	a_b_hold: assert property (
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
		&& $stable(s_axi_bresp_o)) else $error("write response lost");
	a_r_hold: assert property (
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
		&& $stable({s_axi_rresp_o, s_axi_rdata_o}))
		else $error("read data lost");
	a_m_hold: assert property (
		m_axis_tvalid_o && !m_axis_tready_i |=> m_axis_tvalid_o
		&& $stable({m_axis_tlast_o, m_axis_tdata_o}))
		else $error("outbound word lost");
	a_aw_pair: assert property (
		s_axi_awready_o == s_axi_wready_o)
		else $error("address and data ready apart");
	a_b_code: assert property (
		s_axi_bvalid_o |-> s_axi_bresp_o != 2'h1) else $error("bad bresp");
	a_r_code: assert property (
		s_axi_rvalid_o |-> s_axi_rresp_o != 2'h1) else $error("bad rresp");
	a_r_idle: assert property (
		!s_axi_rvalid_o |-> s_axi_rdata_o == '0 && s_axi_rresp_o == 2'h0)
		else $error("read outputs not idle");
	a_ar_lat: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> !s_axi_arready_o
		##1 s_axi_rvalid_o) else $error("read latency wrong");
	c_dec: cover property (s_axi_bvalid_o && s_axi_bresp_o == MBX_RESP_DECERR);
	c_slv: cover property (s_axi_rvalid_o && s_axi_rresp_o == MBX_RESP_SLVERR);
	c_last: cover property (m_axis_tvalid_o && m_axis_tready_i && m_axis_tlast_o);
endmodule
`default_nettype wire

// >>> verif/mbx_stream_sink.sv
// far-side sink for the mailbox outbound stream
// mode 0 always ready, 1 every other cycle, 2 stalled
`timescale 1ns/1ps
`default_nettype none
module mbx_stream_sink (
	// clock and pace
	input wire logic		clk_sys_i,
	input wire logic [1:0]	mode_i,
	// stream in
	input wire logic [31:0]	tdata_i,
	input wire logic		tlast_i,
	input wire logic		tvalid_i,
	output logic		tready_o = 1'h0,
	// word taken at the last edge
	output logic [32:0]	word_o,
	output logic		took_o = 1'h0
);
	logic ph_r = 1'h0;
	always @(posedge clk_sys_i) begin
		ph_r <= ~ph_r;
		tready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && ph_r);
		took_o <= tvalid_i && tready_o;
		word_o <= {tlast_i, tdata_i};
	end
endmodule
`default_nettype wire

// >>> verif/tb_mbx_axi_port.sv
// self-checking bench for mbx_axi_port with a stream sink
// ce_i high except four cycles in the enable check; outbound words checked as the sink takes them
`timescale 1ns/1ps
`default_nettype none
module tb_mbx_axi_port
	import mbx_pkg::*;
;
	localparam int DEP = 4;
	typedef struct packed {
		logic w;
		logic [3:0] a;
		logic [1:0] r;
		logic [31:0] d;
	} mbx_row_s;
	logic clk_sys_i = 1'h0, srst_i = 1'h1, ce_i = 1'h1, s_axi_aresetn_i = 1'h1;
	logic [31:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0, rdat;
	logic [31:0] s_axi_wdata_i = '0, s_axis_tdata_i = '0;
	logic [31:0] s_axi_rdata_o, m_axis_tdata_o;
	logic [3:0] s_axi_wstrb_i = '0;
	logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, s_axis_tlast_i = 1'h0;
	logic s_axis_tvalid_i = 1'h0, m_axis_tready_i, s_axi_awready_o;
	logic s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic s_axis_tready_o, m_axis_tlast_o, m_axis_tvalid_o, took;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp, mode = 2'h0;
	logic [32:0] word, q[$];
	int err_total = 0, cmp_count = 0;
	mbx_row_s rows [9] = '{
		'{1'h1, 4'h0, MBX_RESP_OKAY, 32'h1234_5678},
		'{1'h1, 4'h4, MBX_RESP_OKAY, 32'hcafe_0001},
		'{1'h1, 4'h8, MBX_RESP_SLVERR, 32'h0},
		'{1'h1, 4'h2, MBX_RESP_DECERR, 32'h0},
		'{1'h0, 4'h0, MBX_RESP_SLVERR, 32'h0},
		'{1'h0, 4'h4, MBX_RESP_SLVERR, 32'h0},
		'{1'h0, 4'h8, MBX_RESP_SLVERR, 32'h0},
		'{1'h0, 4'h6, MBX_RESP_DECERR, 32'h0},
		'{1'h0, 4'hc, MBX_RESP_OKAY, 32'h1}};
	always #5 clk_sys_i = ~clk_sys_i;
	mbx_axi_port #(.DEPTH(DEP)) mbx_axi_port_i (
		.clk_sys_i(clk_sys_i), .ce_i(ce_i), .srst_i(srst_i),
		.s_axi_aresetn_i(s_axi_aresetn_i),
		.s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
		.s_axis_tdata_i(s_axis_tdata_i), .s_axis_tlast_i(s_axis_tlast_i),
		.s_axis_tvalid_i(s_axis_tvalid_i), .s_axis_tready_o(s_axis_tready_o),
		.m_axis_tdata_o(m_axis_tdata_o), .m_axis_tlast_o(m_axis_tlast_o),
		.m_axis_tvalid_o(m_axis_tvalid_o), .m_axis_tready_i(m_axis_tready_i)
	);
	mbx_stream_sink mbx_stream_sink_i (.clk_sys_i(clk_sys_i), .mode_i(mode),
		.tdata_i(m_axis_tdata_o), .tlast_i(m_axis_tlast_o),
		.tvalid_i(m_axis_tvalid_o), .tready_o(m_axis_tready_i),
		.word_o(word), .took_o(took));
	task automatic chk(input string nm, input logic [33:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic upto(ref logic s);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (s !== 1'h1 && n < 40);
	endtask
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		if (w) begin
			s_axi_awaddr_i <= {28'h0, a};
			s_axi_wdata_i <= d;
			s_axi_wstrb_i <= d[3:0];
			s_axi_awvalid_i <= 1'h1;
			s_axi_wvalid_i <= 1'h1;
			upto(s_axi_wready_o);
			s_axi_awvalid_i <= 1'h0;
			s_axi_wvalid_i <= 1'h0;
			upto(s_axi_bvalid_o);
			s_axi_bready_i <= 1'h1;
		end else begin
			s_axi_araddr_i <= {28'h0, a};
			s_axi_arvalid_i <= 1'h1;
			upto(s_axi_arready_o);
			s_axi_arvalid_i <= 1'h0;
			upto(s_axi_rvalid_o);
			s_axi_rready_i <= 1'h1;
		end
		@(posedge clk_sys_i);
		resp = w ? s_axi_bresp_o : s_axi_rresp_o;
		rdat = s_axi_rdata_o;
		s_axi_bready_i <= 1'h0;
		s_axi_rready_i <= 1'h0;
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys_i)
		if (took === 1'h1)
			chk("mword", word, q.pop_front());
	// the whole run needs under 2000 cycles
	initial begin
		#100000;
		err_total++;
		tally_and_finish;
	end
	initial begin
		int n;
		int k;
		repeat (12) @(posedge clk_sys_i);
		srst_i <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
		foreach (rows[i]) begin
			if (rows[i].w && rows[i].r == MBX_RESP_OKAY)
				q.push_back({rows[i].a[2], rows[i].d});
			xfer(rows[i].w, rows[i].a, rows[i].d);
			chk("resp", resp, rows[i].r);
			chk("rdata", rdat, rows[i].w ? '0 : rows[i].d);
		end
		$display("rows done");
		s_axis_tvalid_i <= 1'h1;
		n = 0;
		for (k = 0; k < 30; k++) begin
			s_axis_tdata_i <= 32'ha000 + n;
			s_axis_tlast_i <= n == DEP;
			@(posedge clk_sys_i);
			n += s_axis_tready_o === 1'h1;
		end
		s_axis_tvalid_i <= 1'h0;
		chk("fill", n, DEP + 1);
		for (k = 0; k <= DEP; k++) begin
			xfer(1'h0, 4'h8, '0);
			chk("pop", {resp, rdat}, {MBX_RESP_OKAY, 32'ha000 + k});
		end
		xfer(1'h0, 4'hc, '0);
		chk("status", rdat, 32'h5);
		$display("inbound done");
		mode <= 2'h2;
		for (k = 0; k <= DEP + 1; k++) begin
			if (k <= DEP)
				q.push_back({1'h0, 32'hb0 + k});
			xfer(1'h1, 4'h0, 32'hb0 + k);
			chk("txresp", resp, k <= DEP ? MBX_RESP_OKAY : MBX_RESP_SLVERR);
		end
		// stalled sink: tx queue full, rx empty, last flag still set
		xfer(1'h0, 4'hc, '0);
		chk("txfull", rdat, 32'h7);
		mode <= 2'h1;
		n = 0;
		while (q.size() != 0 && n++ < 300)
			@(posedge clk_sys_i);
		chk("txleft", q.size(), 0);
		$display("outbound done");
		// enable low: inbound word offered but nothing may be stored
		ce_i <= 1'h0;
		s_axis_tvalid_i <= 1'h1;
		repeat (4) @(posedge clk_sys_i);
		ce_i <= 1'h1;
		s_axis_tvalid_i <= 1'h0;
		xfer(1'h0, 4'hc, '0);
		chk("frozen", rdat, 32'h5);
		$display("enable done");
		s_axi_aresetn_i <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
		s_axi_aresetn_i <= 1'h1;
		@(posedge clk_sys_i);
		chk("tready", s_axis_tready_o, 1'h0);
		chk("arready", s_axi_arready_o, 1'h1);
		xfer(1'h0, 4'hc, '0);
		chk("status", rdat, 32'h1);
		$display("reset done");
		tally_and_finish;
	end
endmodule
bind mbx_axi_port mbx_checker #(.DW(DW)) mbx_checker_i (
	.clk_sys_i(clk_sys_i), .srst_i(srst_i),
	.s_axi_aresetn_i(s_axi_aresetn_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.s_axis_tready_o(s_axis_tready_o),
	.m_axis_tdata_o(m_axis_tdata_o), .m_axis_tlast_o(m_axis_tlast_o),
	.m_axis_tvalid_o(m_axis_tvalid_o), .m_axis_tready_i(m_axis_tready_i)
);
`default_nettype wire
